// ===== include/ahp_pkg.sv
// Constants shared by the host port, the host model and the testbench
package ahp_pkg;
    // Data bus and register widths, and sample FIFO depth
    localparam int DATA_W = 12;
    localparam int REG_W = 10;
    localparam int FIFO_DEPTH = 8;
    // Register index carried in data bits 11:10 of a write
    localparam int IDX_HI = 11;
    localparam int IDX_LO = 10;
    localparam logic [1:0] IDX_CTRL0 = 2'h0;
    localparam logic [1:0] IDX_CTRL1 = 2'h1;
    // Second control register field positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_RW_MODE = 6;
    localparam int BIT_STRAIGHT_BINARY = 7;
    localparam int BIT_OFFSET_CAL = 8;
    localparam int BIT_CONFIG_ECHO = 9;
    // Values after reset, and the midscale code
    localparam logic [9:0] CTRL0_RESET = 10'h020;
    localparam logic [9:0] CTRL1_RESET = 10'h030;
    localparam logic [11:0] MIDSCALE = 12'h800;
    localparam logic [11:0] ZERO_WORD = 12'h000;
    // Configuration echo sequence
    typedef enum logic [1:0] {
        ECHO_OFF = 2'b00,
        ECHO_REG0 = 2'b01,
        ECHO_REG1 = 2'b10
    } ahp_echo_t;
endpackage

// ===== verilog/ahp_strobe_gate.sv
// Combines the two selects with the read and write pins into internal strobes
`timescale 1ns/10ps
module ahp_strobe_gate
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic select_low_n,
    input wire logic select_high,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic rw_mode,
    output logic internal_read_pulse,
    output logic internal_write_pulse,
    output logic read_start,
    output logic write_end
);
    logic selected;
    logic read_req;
    logic write_req;
    logic rd_prev_r;
    logic wr_prev_r;

    assign selected = !select_low_n && select_high;
    assign read_req = rw_mode ? write_n : !read_n;
    assign write_req = rw_mode ? !write_n : !write_n;
    assign internal_read_pulse = selected && read_req && (rw_mode || write_n);
    assign internal_write_pulse = selected && write_req && (rw_mode || read_n);
    assign read_start = internal_read_pulse && !rd_prev_r;
    assign write_end = wr_prev_r && !internal_write_pulse;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
        end
        else
        begin
            rd_prev_r <= internal_read_pulse;
            wr_prev_r <= internal_write_pulse;
        end
    end
endmodule // ahp_strobe_gate

// ===== verilog/ahp_fifo.sv
// Flip-flop FIFO with valid and ready on both sides and registered flags
`timescale 1ns/10ps
module ahp_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;
    logic not_full_r;
    logic not_empty_r;

    assign push = in_valid && not_full_r;
    assign pop = out_ready && not_empty_r;
    assign count_nxt = flush ? '0 : count_r + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = not_full_r;
    assign out_valid = not_empty_r;
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            not_full_r <= 1'b1;
            not_empty_r <= 1'b0;
        end
        else
        begin
            wr_ptr_r <= flush ? '0 : (push ? AW'((wr_ptr_r + 1'b1) % DEPTH) : wr_ptr_r);
            rd_ptr_r <= flush ? '0 : (pop ? AW'((rd_ptr_r + 1'b1) % DEPTH) : rd_ptr_r);
            count_r <= count_nxt;
            not_full_r <= count_nxt != (AW+1)'(DEPTH);
            not_empty_r <= count_nxt != '0;
        end
    end
endmodule // ahp_fifo

// ===== verilog/ahp_host_port.sv
// Parallel host port: control registers, strobe handling, offset and format of results
`timescale 1ns/10ps
module ahp_host_port
#(
    parameter int DATA_W = ahp_pkg::DATA_W,
    parameter int FIFO_DEPTH = ahp_pkg::FIFO_DEPTH
)
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic SELECT_LOW_N,
    input wire logic SELECT_HIGH,
    input wire logic READ_N,
    input wire logic WRITE_N,
    input wire logic [DATA_W-1:0] DATA_IN,
    output logic [DATA_W-1:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic SAMPLE_VALID,
    input wire logic [DATA_W-1:0] SAMPLE_DATA,
    output logic SAMPLE_READY,
    output logic FORCE_ZERO_INPUT,
    output logic DEVICE_IN_RESET,
    output logic [ahp_pkg::REG_W-1:0] CTRL0_VALUE,
    output logic [ahp_pkg::REG_W-1:0] CTRL1_VALUE
);
    logic internal_read_pulse;
    logic internal_write_pulse;
    logic read_start;
    logic write_end;
    logic rw_mode;
    logic [ahp_pkg::REG_W-1:0] ctrl0_r;
    logic [ahp_pkg::REG_W-1:0] ctrl1_r;
    logic [DATA_W-1:0] wr_word_r;
    logic [DATA_W-1:0] offset_r;
    logic [DATA_W-1:0] dout_r;
    logic doe_r;
    logic in_reset_r;
    logic cal_pending_r;
    ahp_pkg::ahp_echo_t echo_r;
    ahp_pkg::ahp_echo_t echo_nxt;
    logic [1:0] wr_idx;
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic soft_reset_set;
    logic soft_reset_clear;
    logic sample_take;
    logic cal_take;
    logic push_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [DATA_W-1:0] fifo_out_data;
    logic [DATA_W-1:0] corrected;
    logic [DATA_W-1:0] formatted;
    logic [DATA_W-1:0] read_word;

    function automatic logic [DATA_W-1:0] widen(input logic [ahp_pkg::REG_W-1:0] v);
        widen = {{(DATA_W-ahp_pkg::REG_W){1'b0}}, v};
    endfunction

    assign rw_mode = ctrl1_r[ahp_pkg::BIT_RW_MODE];

    ahp_strobe_gate u_gate
    (
        .clk(CLOCK),
        .rst_b(RST_B),
        .select_low_n(SELECT_LOW_N),
        .select_high(SELECT_HIGH),
        .read_n(READ_N),
        .write_n(WRITE_N),
        .rw_mode(rw_mode),
        .internal_read_pulse(internal_read_pulse),
        .internal_write_pulse(internal_write_pulse),
        .read_start(read_start),
        .write_end(write_end)
    );

    // Register write decode from the word held at the end of the pulse
    assign wr_idx = wr_word_r[ahp_pkg::IDX_HI:ahp_pkg::IDX_LO];
    assign wr_ctrl0 = write_end && (wr_idx == ahp_pkg::IDX_CTRL0) && !in_reset_r;
    assign wr_ctrl1 = write_end && (wr_idx == ahp_pkg::IDX_CTRL1);
    assign soft_reset_set = wr_ctrl1 && wr_word_r[ahp_pkg::BIT_SOFT_RESET];
    assign soft_reset_clear = wr_ctrl1 && !wr_word_r[ahp_pkg::BIT_SOFT_RESET];

    // Sample path
    assign sample_take = SAMPLE_VALID && fifo_in_ready && !in_reset_r;
    assign cal_take = sample_take && cal_pending_r;
    assign push_valid = sample_take && !cal_pending_r;
    assign corrected = SAMPLE_DATA - offset_r;
    assign formatted = ctrl1_r[ahp_pkg::BIT_STRAIGHT_BINARY] ? corrected : (corrected ^ ahp_pkg::MIDSCALE);

    ahp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(CLOCK),
        .rst_b(RST_B),
        .flush(in_reset_r),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(formatted),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Read source selection
    // Echo reads return the first then the second control register, otherwise the buffered result, or the last output word when the buffer is empty
    assign read_word = (echo_r == ahp_pkg::ECHO_REG0) ? widen(ctrl0_r) :
                       (echo_r == ahp_pkg::ECHO_REG1) ? widen(ctrl1_r) :
                       (fifo_out_valid ? fifo_out_data : dout_r);
    assign fifo_pop = read_start && (echo_r == ahp_pkg::ECHO_OFF);

    always_comb
    begin
        echo_nxt = echo_r;
        unique case (echo_r)
            ahp_pkg::ECHO_OFF:
                echo_nxt = ahp_pkg::ECHO_OFF;
            ahp_pkg::ECHO_REG0:
                echo_nxt = read_start ? ahp_pkg::ECHO_REG1 : ahp_pkg::ECHO_REG0;
            ahp_pkg::ECHO_REG1:
                echo_nxt = read_start ? ahp_pkg::ECHO_OFF : ahp_pkg::ECHO_REG1;
            default:
                echo_nxt = ahp_pkg::ECHO_OFF;
        endcase
        if (in_reset_r || soft_reset_set || (wr_ctrl1 && !wr_word_r[ahp_pkg::BIT_CONFIG_ECHO]))
            echo_nxt = ahp_pkg::ECHO_OFF;
        else if (wr_ctrl1)
            echo_nxt = ahp_pkg::ECHO_REG0;
    end

    // Bus word capture while the write pulse is active
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            wr_word_r <= ahp_pkg::ZERO_WORD;
        else if (internal_write_pulse)
            wr_word_r <= DATA_IN;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ctrl0_r <= ahp_pkg::CTRL0_RESET;
            ctrl1_r <= ahp_pkg::CTRL1_RESET;
        end
        else if (soft_reset_set)
        begin
            ctrl0_r <= ahp_pkg::CTRL0_RESET;
            ctrl1_r <= ahp_pkg::CTRL1_RESET | 10'h001;
        end
        else if (wr_ctrl1)
            ctrl1_r <= wr_word_r[ahp_pkg::REG_W-1:0];
        else if (wr_ctrl0)
            ctrl0_r <= wr_word_r[ahp_pkg::REG_W-1:0];
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            in_reset_r <= 1'b0;
        else if (soft_reset_set)
            in_reset_r <= 1'b1;
        else if (soft_reset_clear)
            in_reset_r <= 1'b0;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cal_pending_r <= 1'b0;
            offset_r <= ahp_pkg::ZERO_WORD;
        end
        else if (in_reset_r || soft_reset_set)
        begin
            cal_pending_r <= 1'b0;
            offset_r <= ahp_pkg::ZERO_WORD;
        end
        else if (wr_ctrl1 && wr_word_r[ahp_pkg::BIT_OFFSET_CAL])
            cal_pending_r <= 1'b1;
        else if (cal_take)
        begin
            cal_pending_r <= 1'b0;
            offset_r <= SAMPLE_DATA - ahp_pkg::MIDSCALE;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            echo_r <= ahp_pkg::ECHO_OFF;
        else
            echo_r <= echo_nxt;
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            dout_r <= ahp_pkg::ZERO_WORD;
            doe_r <= 1'b0;
        end
        else
        begin
            doe_r <= internal_read_pulse;
            if (read_start)
                dout_r <= read_word;
        end
    end

    assign DATA_OUT = dout_r;
    assign DATA_OE = doe_r;
    assign SAMPLE_READY = fifo_in_ready;
    assign FORCE_ZERO_INPUT = cal_pending_r;
    assign DEVICE_IN_RESET = in_reset_r;
    assign CTRL0_VALUE = ctrl0_r;
    assign CTRL1_VALUE = ctrl1_r;

    rst_enter_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        soft_reset_set |=> in_reset_r && ctrl0_r == ahp_pkg::CTRL0_RESET && !ctrl1_r[ahp_pkg::BIT_RW_MODE])
        else $error("soft reset did not load reset values");

    rst_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        in_reset_r && !soft_reset_clear |=> in_reset_r)
        else $error("device left reset without a clearing write");

    rw_dir_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        rw_mode && !SELECT_LOW_N && SELECT_HIGH |-> internal_read_pulse == WRITE_N)
        else $error("combined direction pin not honoured");

    split_strobe_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !rw_mode && !SELECT_LOW_N && SELECT_HIGH && !READ_N && WRITE_N |-> internal_read_pulse)
        else $error("separate read strobe not honoured");

    bin_format_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        push_valid && !ctrl1_r[ahp_pkg::BIT_STRAIGHT_BINARY] |-> formatted == DATA_W'(SAMPLE_DATA - offset_r - ahp_pkg::MIDSCALE))
        else $error("two's complement format wrong");

    cal_store_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        cal_take && !in_reset_r && !wr_ctrl1 |=> !cal_pending_r && offset_r == $past(SAMPLE_DATA) - ahp_pkg::MIDSCALE)
        else $error("offset not stored from calibration sample");

    echo_first_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        read_start && echo_r == ahp_pkg::ECHO_REG0 && !write_end |=> dout_r == widen($past(ctrl0_r)) ##0 echo_r == ahp_pkg::ECHO_REG1)
        else $error("first echo read wrong");

    echo_second_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        read_start && echo_r == ahp_pkg::ECHO_REG1 && !write_end |=> dout_r == widen($past(ctrl1_r)))
        else $error("second echo read wrong");

    read_excl_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !rw_mode && !WRITE_N |-> !internal_read_pulse)
        else $error("read pulse during write strobe");

    oe_follow_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        DATA_OE == $past(internal_read_pulse))
        else $error("buffer enable does not follow read pulse");

    write_excl_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !rw_mode && !READ_N |-> !internal_write_pulse)
        else $error("write pulse during read strobe");

    reg_latch_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr_ctrl0 && !wr_ctrl1 |=> ctrl0_r == $past(wr_word_r[ahp_pkg::REG_W-1:0]))
        else $error("first control register not latched");

    read_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        internal_read_pulse |-> !SELECT_LOW_N && SELECT_HIGH)
        else $error("read pulse without both selects");

    write_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        internal_write_pulse |-> !SELECT_LOW_N && SELECT_HIGH && !WRITE_N)
        else $error("write pulse without selects and write pin");

    rst_ctrl1_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        soft_reset_set |=> ctrl1_r[ahp_pkg::BIT_SOFT_RESET]
            && ctrl1_r[ahp_pkg::REG_W-1:1] == ahp_pkg::CTRL1_RESET[ahp_pkg::REG_W-1:1])
        else $error("soft reset did not load second register");

    rst_ctrl0_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        in_reset_r |-> ctrl0_r == ahp_pkg::CTRL0_RESET)
        else $error("first control register changed during soft reset");

    rst_flush_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        in_reset_r |=> !fifo_out_valid)
        else $error("results held during soft reset");

    straight_bin_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        push_valid && ctrl1_r[ahp_pkg::BIT_STRAIGHT_BINARY] |-> formatted == DATA_W'(SAMPLE_DATA - offset_r))
        else $error("offset not removed from result");

    cal_arm_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr_ctrl1 && wr_word_r[ahp_pkg::BIT_OFFSET_CAL] && !wr_word_r[ahp_pkg::BIT_SOFT_RESET] && !in_reset_r
        |=> FORCE_ZERO_INPUT)
        else $error("calibration not started by write");

    offset_keep_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !cal_take && !in_reset_r && !soft_reset_set |=> $stable(offset_r))
        else $error("stored offset changed without calibration");

    echo_arm_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr_ctrl1 && wr_word_r[ahp_pkg::BIT_CONFIG_ECHO] && !wr_word_r[ahp_pkg::BIT_SOFT_RESET] && !in_reset_r
        |=> echo_r == ahp_pkg::ECHO_REG0)
        else $error("echo not armed by write");

    echo_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr_ctrl1 && !wr_word_r[ahp_pkg::BIT_CONFIG_ECHO] |=> echo_r == ahp_pkg::ECHO_OFF)
        else $error("echo not cleared by write");

    data_pop_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        read_start && echo_r == ahp_pkg::ECHO_OFF && fifo_out_valid |=> DATA_OE && DATA_OUT == $past(fifo_out_data))
        else $error("read did not present buffered result");

    data_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !read_start |=> $stable(DATA_OUT))
        else $error("output word changed outside a read");

    ctrl1_latch_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        wr_ctrl1 && !wr_word_r[ahp_pkg::BIT_SOFT_RESET] |=> ctrl1_r == $past(wr_word_r[ahp_pkg::REG_W-1:0]))
        else $error("second control register not latched");
endmodule // ahp_host_port

// ===== testbench/ahp_host_model.sv
// Host processor model driving the parallel port strobes and data bus
`timescale 1ns/10ps
module ahp_host_model
(
    input wire logic clk,
    input wire logic [ahp_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    output logic select_low_n,
    output logic select_high,
    output logic read_n,
    output logic write_n,
    output logic [ahp_pkg::DATA_W-1:0] data_in
);
    logic combined = 1'b0;
    logic [ahp_pkg::DATA_W-1:0] last_word = 12'h000;

    initial
    begin
        select_low_n = 1'b1;
        select_high = 1'b0;
        read_n = 1'b1;
        write_n = 1'b1;
        data_in = 12'hFFF;
    end

    // Selects off; a released bus shows the inverse of the last word
    task automatic go_idle();
        select_low_n <= 1'b1;
        select_high <= 1'b0;
        // read pin left low in combined mode
        read_n <= ~combined;
        write_n <= 1'b1;
        data_in <= ~last_word;
        repeat (2) @(posedge clk);
    endtask

    task automatic write_word(input logic [1:0] idx, input logic [9:0] val);
        last_word = {idx, idx == ahp_pkg::IDX_CTRL1 ? val & 10'h3C1 : val};
        select_low_n <= 1'b0;
        select_high <= 1'b1;
        read_n <= ~combined;
        write_n <= 1'b0;
        data_in <= last_word;
        repeat (2) @(posedge clk);
        go_idle();
        @(posedge clk);
    endtask

    task automatic read_word(output logic [ahp_pkg::DATA_W-1:0] word);
        int n;
        n = 0;
        select_low_n <= 1'b0;
        select_high <= 1'b1;
        read_n <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (data_oe !== 1'b1 && n < 20);
        // A read that never got its enable returns unknown so the compare fails
        word = (data_oe === 1'b1) ? data_out : 'x;
        go_idle();
    endtask

    // Read and write strobes both low; bus stays held until go_idle
    task automatic clash(input logic [ahp_pkg::DATA_W-1:0] word);
        last_word = word;
        select_low_n <= 1'b0;
        select_high <= 1'b1;
        read_n <= 1'b0;
        write_n <= 1'b0;
        data_in <= word;
        repeat (3) @(posedge clk);
    endtask
endmodule // ahp_host_model

// ===== testbench/adc_host_port_ctrl_reg1_tb.sv
// Self-checking bench for the parallel host port with host model and sample source
`timescale 1ns/10ps
module adc_host_port_ctrl_reg1_tb;
    typedef struct {logic [9:0] ctrl1; logic [11:0] smp; logic [11:0] word;} ahp_row_t;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic sample_valid = 1'b0;
    logic [11:0] sample_data = 12'h000;
    logic sel_low_n, sel_high, rd_n, wr_n, data_oe, sample_ready, force_zero, in_reset;
    logic [11:0] data_in, data_out, rd_word;
    logic [9:0] ctrl0, ctrl1;
    int err_total = 0;
    int total_checks = 0;
    ahp_row_t rows [6] = '{'{10'h000, 12'h800, 12'h000}, '{10'h000, 12'hFFF, 12'h7FF},
        '{10'h080, 12'h800, 12'h800}, '{10'h080, 12'h123, 12'h123},
        '{10'h040, 12'h001, 12'h801}, '{10'h0C0, 12'hABC, 12'hABC}};

    always #4 clock = ~clock;

    ahp_host_port DUT
    (
        .CLOCK(clock),
        .RST_B(rst_b),
        .SELECT_LOW_N(sel_low_n),
        .SELECT_HIGH(sel_high),
        .READ_N(rd_n),
        .WRITE_N(wr_n),
        .DATA_IN(data_in),
        .DATA_OUT(data_out),
        .DATA_OE(data_oe),
        .SAMPLE_VALID(sample_valid),
        .SAMPLE_DATA(sample_data),
        .SAMPLE_READY(sample_ready),
        .FORCE_ZERO_INPUT(force_zero),
        .DEVICE_IN_RESET(in_reset),
        .CTRL0_VALUE(ctrl0),
        .CTRL1_VALUE(ctrl1)
    );

    ahp_host_model host
    (
        .clk(clock),
        .data_out(data_out),
        .data_oe(data_oe),
        .select_low_n(sel_low_n),
        .select_high(sel_high),
        .read_n(rd_n),
        .write_n(wr_n),
        .data_in(data_in)
    );

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic push(input logic [11:0] w);
        int n;
        n = 0;
        sample_data <= w;
        sample_valid <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (sample_ready !== 1'b1 && n < 20);
        if (sample_ready !== 1'b1)
            chk({11'h000, sample_ready}, 12'h001);
    endtask

    task automatic push_read(input logic [11:0] w, input logic [11:0] exp);
        push(w);
        sample_valid <= 1'b0;
        @(posedge clock);
        host.read_word(rd_word);
        chk(rd_word, exp);
        chk({11'h000, data_oe}, 12'h000);
    endtask

    task automatic check_reset();
        chk({2'b00, ctrl0}, {2'b00, ahp_pkg::CTRL0_RESET});
        chk({2'b00, ctrl1}, {2'b00, ahp_pkg::CTRL1_RESET});
        chk({8'h00, data_oe, sample_ready, force_zero, in_reset}, 12'h004);
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #60000;
        err_total++;
        $display("watchdog expired at %0t ns", $time);
        give_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clock);
        check_reset();
        rst_b <= 1'b1;
        @(posedge clock);
        done("reset");
        foreach (rows[i])
        begin
            host.write_word(ahp_pkg::IDX_CTRL1, rows[i].ctrl1);
            chk({2'b00, ctrl1}, {2'b00, rows[i].ctrl1});
            host.combined = rows[i].ctrl1[ahp_pkg::BIT_RW_MODE];
            push_read(rows[i].smp, rows[i].word);
        end
        host.write_word(ahp_pkg::IDX_CTRL1, 10'h080);
        host.combined = 1'b0;
        done("format and mode table");
        host.write_word(ahp_pkg::IDX_CTRL0, 10'h155);
        host.write_word(2'h2, 10'h3FF);
        chk({ctrl1, 2'b00}, 12'h200);
        chk({2'b00, ctrl0}, 12'h155);
        host.write_word(ahp_pkg::IDX_CTRL1, 10'h280);
        host.read_word(rd_word);
        chk(rd_word, 12'h155);
        host.read_word(rd_word);
        chk(rd_word, 12'h280);
        host.write_word(ahp_pkg::IDX_CTRL1, 10'h080);
        push_read(12'h456, 12'h456);
        done("register echo");
        host.clash(12'h4C0);
        chk({11'h000, data_oe}, 12'h000);
        host.go_idle();
        @(posedge clock);
        chk({2'b00, ctrl1}, 12'h080);
        done("strobe clash");
        for (int i = 0; i < 8; i++)
            push(12'h100 + 12'(i));
        sample_data <= 12'hFFF;
        repeat (3) @(posedge clock);
        sample_valid <= 1'b0;
        chk({11'h000, sample_ready}, 12'h000);
        for (int i = 0; i < 9; i++)
        begin
            host.read_word(rd_word);
            chk(rd_word, 12'h100 + 12'(i < 8 ? i : 7));
        end
        chk({11'h000, sample_ready}, 12'h001);
        done("buffer fill and drain");
        host.write_word(ahp_pkg::IDX_CTRL1, 10'h100);
        chk({11'h000, force_zero}, 12'h001);
        push(12'h810);
        sample_valid <= 1'b0;
        repeat (2) @(posedge clock);
        chk({11'h000, force_zero}, 12'h000);
        push_read(12'h900, 12'h0F0);
        push_read(12'h850, 12'h040);
        done("offset calibration");
        host.write_word(ahp_pkg::IDX_CTRL1, 10'h081);
        chk({in_reset, 1'b0, ctrl1}, 12'h831);
        host.write_word(ahp_pkg::IDX_CTRL0, 10'h3FF);
        chk({2'b00, ctrl0}, {2'b00, ahp_pkg::CTRL0_RESET});
        host.write_word(ahp_pkg::IDX_CTRL1, 10'h000);
        chk({in_reset, 1'b0, ctrl1}, 12'h000);
        push_read(12'h800, 12'h000);
        done("soft reset");
        host.write_word(ahp_pkg::IDX_CTRL0, 10'h0AA);
        chk({2'b00, ctrl0}, 12'h0AA);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        check_reset();
        rst_b <= 1'b1;
        @(posedge clock);
        done("reset in mid-run");
        give_verdict();
    end
endmodule // adc_host_port_ctrl_reg1_tb
